// [logic/move_space_multiply_decode.sv]
/*
  Execute block for four instructions: byte-lane move, quick immediate
  move, alternate address-space move and signed multiply.
  Assumes a dispatcher that presents only words of these four families
  together with the second word, the effective address already resolved,
  and the source operand already fetched; a register file with two read
  ports (data in the same cycle as the index) and one write port; a bus
  controller that answers each request with a one-cycle acknowledge.
*/
// Summary of operation
// - byte-lane move steps its address by two, register high byte first
// - lane opmode 100/101 loads word/long, 110/111 stores word/long
// - lane address is address register plus signed 16-bit displacement
// - odd-address lane bytes travel on the low data-bus half
// - quick move sign-extends the 8-bit field into the data register
// - quick move sets N and Z, clears V and C, keeps X
// - quick move is 0111 in 15..12 with bit 8 clear
// - address-space move in user state takes a privilege trap
// - address-space writes use dest_space_code, reads source_space_code
// - data register load changes low bits only; address register sign-extended
// - address-space size 00 byte, 01 word, 10 long
// - extension type bit picks data (0) or address (1) register
// - direction_bit 0 memory to register, 1 register to memory
// - address-space move accepts memory-alterable modes only
// - self-referencing postincrement/predecrement store writes adjusted address
// - word multiply: signed 16x16 low words to a 32-bit product
// - long multiply: signed 32x32, 32-bit or 64-bit result
// - V only in 32-bit long form, set when upper half not sign extension
// - multiply sets N and Z, clears C, keeps X
// - multiply source accepts data addressing modes only
// - size bit 0 writes low register, 1 writes high and low pair
// - equal high and low register numbers give an undefined result
`timescale 1ns/1ps
`default_nettype none

module move_space_multiply_decode (
	input  wire logic        clk_sys,          // core clock
	input  wire logic        reset_n,          // synchronous reset
	input  wire logic        instrValid,       // operation presented
	input  wire logic [15:0] opWord,           // first instruction word
	input  wire logic [15:0] extWord,          // second instruction word
	input  wire logic [31:0] srcOperand,       // fetched multiply source
	input  wire logic [31:0] eaAddr,           // resolved effective address
	input  wire logic [31:0] eaAdjAddr,        // address register after adjust
	input  wire logic        supervisor,       // supervisor state
	input  wire logic [2:0]  sourceSpaceCode,  // source space code register
	input  wire logic [2:0]  destSpaceCode,    // dest space code register
	input  wire logic [4:0]  ccrIn,            // current condition codes
	input  wire logic [31:0] regRdDataA,       // read port A data
	input  wire logic [31:0] regRdDataB,       // read port B data
	input  wire logic        busAck,           // bus cycle complete
	input  wire logic [31:0] busRData,         // bus read data
	output logic             busy,             // operation in progress
	output logic [3:0]       regRdIdxA,        // read port A index
	output logic [3:0]       regRdIdxB,        // read port B index
	output logic             regWrEn,          // register write pulse
	output logic [3:0]       regWrIdx,         // {address?, number}
	output logic [31:0]      regWrData,        // register write data
	output logic             ccrWrEn,          // condition-code write pulse
	output logic [4:0]       ccrOut,           // new condition codes
	output logic             busReq,           // bus request level
	output logic             busWrite,         // 1 = write cycle
	output logic [31:0]      busAddr,          // bus address
	output logic [1:0]       busSize,          // bus operand size
	output logic [2:0]       busFc,            // bus function code
	output logic [31:0]      busWData,         // bus write data
	output logic             trapPrivilege,    // privilege trap pulse
	output logic             trapIllegal,      // illegal-instruction pulse
	output logic             done              // completion pulse
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic memAlterable(input logic [2:0] m, input logic [2:0] r);
		memAlterable = (m >= 3'h2 && m != move_space_multiply_pkg::EA_EXT) ||
			(m == move_space_multiply_pkg::EA_EXT && r <= move_space_multiply_pkg::EA_ABS_L);
	endfunction : memAlterable

	function automatic logic dataMode(input logic [2:0] m, input logic [2:0] r);
		dataMode = (m != move_space_multiply_pkg::EA_AREG && m != move_space_multiply_pkg::EA_EXT)
			|| (m == move_space_multiply_pkg::EA_EXT && r <= move_space_multiply_pkg::EA_IMM);
	endfunction : dataMode

	function automatic logic [31:0] sizeExtend(input logic [31:0] v, input logic [1:0] sz);
		case (sz)
			move_space_multiply_pkg::SZ_BYTE: sizeExtend = {{24{v[7]}}, v[7:0]};
			move_space_multiply_pkg::SZ_WORD: sizeExtend = {{16{v[15]}}, v[15:0]};
			default:                          sizeExtend = v;
		endcase
	endfunction : sizeExtend

	// byte rides the high half at even addresses, the low half at odd
	function automatic logic [7:0] laneByte(input logic [31:0] d, input logic odd);
		laneByte = odd ? d[7:0] : d[15:8];
	endfunction : laneByte

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_EXEC, ST_BUS, ST_WRHI} state_t;

	state_t      state_r;
	logic [15:0] op_r;
	logic [15:0] ext_r;
	logic [31:0] src_r;
	logic [31:0] ea_r;
	logic [31:0] eaAdj_r;
	logic [31:0] hold_r;       // destination register image
	logic [31:0] shift_r;      // lane bytes, most significant first
	logic [2:0]  left_r;       // lane bytes still to move
	logic [31:0] hiHold_r;     // product high half for the second write

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic [2:0] eaMode   = op_r[5:3];
	wire logic [2:0] eaReg    = op_r[2:0];
	wire logic [2:0] laneMode = op_r[8:6];
	wire logic [1:0] spSize   = op_r[7:6];

	wire logic isQuick = op_r[15:12] == move_space_multiply_pkg::QUICK_TOP && !op_r[8];
	wire logic isLane  = op_r[15:12] == move_space_multiply_pkg::LANE_TOP && op_r[8]
		&& eaMode == move_space_multiply_pkg::LANE_EAMODE;
	wire logic isSpace = op_r[15:8] == move_space_multiply_pkg::SPACE_TOP
		&& spSize != 2'h3 && ext_r[10:0] == 11'h0 && memAlterable(eaMode, eaReg);
	wire logic isMulW  = op_r[15:12] == move_space_multiply_pkg::MULW_TOP
		&& op_r[8:6] == move_space_multiply_pkg::MULW_OPMODE && dataMode(eaMode, eaReg);
	wire logic isMulL  = op_r[15:6] == move_space_multiply_pkg::MULL_TOP && !ext_r[15]
		&& ext_r[move_space_multiply_pkg::EXT_SIGNED_BIT] && ext_r[9:3] == 7'h0
		&& dataMode(eaMode, eaReg);
	wire logic isIllegal = !(isQuick || isLane || isSpace || isMulW || isMulL);

	wire logic mul64    = ext_r[move_space_multiply_pkg::EXT_SIZE_BIT];
	wire logic spToMem  = ext_r[move_space_multiply_pkg::EXT_DIR_BIT];
	wire logic spAddrRg = ext_r[move_space_multiply_pkg::EXT_AD_BIT];
	wire logic laneLoad = laneMode == move_space_multiply_pkg::LANE_LOAD_WORD ||
		laneMode == move_space_multiply_pkg::LANE_LOAD_LONG;
	wire logic laneLong = laneMode == move_space_multiply_pkg::LANE_LOAD_LONG ||
		laneMode == move_space_multiply_pkg::LANE_STORE_LONG;

	// read port A: the data or address register touched; port B: the lane base register
	wire logic [3:0] idxA = isSpace ? ext_r[15:12] :
		isMulL ? {1'b0, ext_r[14:12]} : {1'b0, op_r[11:9]};
	wire logic [3:0] idxB = {1'b1, eaReg};

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	wire logic [31:0] quickVal = {{24{op_r[7]}}, op_r[7:0]};
	wire logic [31:0] prodW = 32'($signed(src_r[15:0]) * $signed(regRdDataA[15:0]));
	wire logic [63:0] prodL = 64'($signed(src_r) * $signed(regRdDataA));
	wire logic mulOvf = isMulL && !mul64 && prodL[63:32] != {32{prodL[31]}};
	wire logic [31:0] mulLow = isMulW ? prodW : prodL[31:0];
	wire logic mulNeg  = isMulW ? prodW[31] : (mul64 ? prodL[63] : prodL[31]);
	wire logic mulZero = isMulW ? prodW == 32'h0 :
		(mul64 ? prodL == 64'h0 : prodL[31:0] == 32'h0);

	wire logic [31:0] laneAddr = regRdDataB + {{16{ext_r[15]}}, ext_r};
	wire logic [31:0] laneImage = laneLong ? regRdDataA : {regRdDataA[15:0], 16'h0};

	// a store of the base register through itself sends the adjusted address
	wire logic selfAdj = spToMem && spAddrRg && ext_r[14:12] == eaReg &&
		(eaMode == move_space_multiply_pkg::EA_POSTINC ||
		 eaMode == move_space_multiply_pkg::EA_PREDEC);
	wire logic [31:0] spStore = selfAdj ? eaAdj_r : regRdDataA;
	wire logic [31:0] spStoreLane = spSize == move_space_multiply_pkg::SZ_BYTE ?
		(ea_r[0] ? {24'h0, spStore[7:0]} : {16'h0, spStore[7:0], 8'h0}) : spStore;
	wire logic [31:0] spLoadRaw = spSize == move_space_multiply_pkg::SZ_BYTE ?
		{24'h0, laneByte(busRData, busAddr[0])} : busRData;
	wire logic [31:0] spLoadVal = spAddrRg ? sizeExtend(spLoadRaw, spSize) :
		spSize == move_space_multiply_pkg::SZ_BYTE ? {hold_r[31:8], spLoadRaw[7:0]} :
		spSize == move_space_multiply_pkg::SZ_WORD ? {hold_r[31:16], spLoadRaw[15:0]} :
		spLoadRaw;

	wire logic [31:0] laneAcc  = {shift_r[23:0], laneByte(busRData, busAddr[0])};
	wire logic [31:0] laneLoadVal = laneLong ? laneAcc : {hold_r[31:16], laneAcc[15:0]};
	wire logic [7:0]  laneNext = shift_r[23:16];
	wire logic [31:0] laneWrNext = busAddr[0] ? {24'h0, laneNext} : {16'h0, laneNext, 8'h0};
	wire logic [31:0] laneWrFirst = laneAddr[0] ? {24'h0, laneImage[31:24]} :
		{16'h0, laneImage[31:24], 8'h0};
	wire logic laneLast = left_r == 3'h1;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		regWrEn       <= 1'b0;
		ccrWrEn       <= 1'b0;
		trapPrivilege <= 1'b0;
		trapIllegal   <= 1'b0;
		done          <= 1'b0;
		if (!reset_n) begin
			state_r   <= ST_IDLE;
			busy      <= 1'b0;
			op_r      <= 16'h0;
			ext_r     <= 16'h0;
			src_r     <= 32'h0;
			ea_r      <= 32'h0;
			eaAdj_r   <= 32'h0;
			hold_r    <= 32'h0;
			shift_r   <= 32'h0;
			left_r    <= 3'h0;
			hiHold_r  <= 32'h0;
			regRdIdxA <= 4'h0;
			regRdIdxB <= 4'h0;
			regWrIdx  <= 4'h0;
			regWrData <= 32'h0;
			ccrOut    <= 5'h0;
			busReq    <= 1'b0;
			busWrite  <= 1'b0;
			busAddr   <= 32'h0;
			busSize   <= 2'h0;
			busFc     <= 3'h0;
			busWData  <= 32'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (instrValid) begin
						op_r    <= opWord;
						ext_r   <= extWord;
						src_r   <= srcOperand;
						ea_r    <= eaAddr;
						eaAdj_r <= eaAdjAddr;
						busy    <= 1'b1;
						state_r <= ST_READ;
					end
				end
				ST_READ: begin
					regRdIdxA <= idxA;
					regRdIdxB <= idxB;
					state_r   <= ST_EXEC;
				end
				ST_EXEC: begin
					hold_r  <= regRdDataA;
					state_r <= ST_IDLE;
					if (isIllegal) begin
						trapIllegal <= 1'b1;
						done        <= 1'b1;
						busy        <= 1'b0;
					end else if (isQuick) begin
						regWrEn   <= 1'b1;
						regWrIdx  <= {1'b0, op_r[11:9]};
						regWrData <= quickVal;
						ccrWrEn   <= 1'b1;
						ccrOut    <= {ccrIn[move_space_multiply_pkg::CC_X], quickVal[31],
							quickVal == 32'h0, 2'b00};
						done      <= 1'b1;
						busy      <= 1'b0;
					end else if (isSpace && !supervisor) begin
						trapPrivilege <= 1'b1;
						done          <= 1'b1;
						busy          <= 1'b0;
					end else if (isSpace) begin
						busReq   <= 1'b1;
						busWrite <= spToMem;
						busAddr  <= ea_r;
						busSize  <= spSize;
						busFc    <= spToMem ? destSpaceCode : sourceSpaceCode;
						busWData <= spStoreLane;
						state_r  <= ST_BUS;
					end else if (isLane) begin
						busReq   <= 1'b1;
						busWrite <= !laneLoad;
						busAddr  <= laneAddr;
						busSize  <= move_space_multiply_pkg::SZ_BYTE;
						busFc    <= supervisor ? 3'h5 : 3'h1;
						busWData <= laneWrFirst;
						shift_r  <= laneLoad ? 32'h0 : laneImage;
						left_r   <= laneLong ? move_space_multiply_pkg::LANE_BYTES_LONG :
							move_space_multiply_pkg::LANE_BYTES_WORD;
						state_r  <= ST_BUS;
					end else begin
						// equal high and low numbers: the high write lands last
						regWrEn   <= 1'b1;
						regWrIdx  <= isMulW ? {1'b0, op_r[11:9]} : {1'b0, ext_r[14:12]};
						regWrData <= mulLow;
						hiHold_r  <= prodL[63:32];
						ccrWrEn   <= 1'b1;
						ccrOut    <= {ccrIn[move_space_multiply_pkg::CC_X], mulNeg, mulZero,
							mulOvf, 1'b0};
						if (isMulL && mul64) begin
							state_r <= ST_WRHI;
						end else begin
							done <= 1'b1;
							busy <= 1'b0;
						end
					end
				end
				ST_BUS: begin
					if (busAck) begin
						if (isSpace || laneLast) begin
							busReq  <= 1'b0;
							done    <= 1'b1;
							busy    <= 1'b0;
							state_r <= ST_IDLE;
						end
						if (isSpace && !spToMem) begin
							regWrEn   <= 1'b1;
							regWrIdx  <= ext_r[15:12];
							regWrData <= spLoadVal;
						end
						if (isLane) begin
							left_r   <= left_r - 3'h1;
							busAddr  <= busAddr + move_space_multiply_pkg::LANE_STEP;
							shift_r  <= laneLoad ? laneAcc : {shift_r[23:0], 8'h0};
							busWData <= laneWrNext;
						end
						if (isLane && laneLast && laneLoad) begin
							regWrEn   <= 1'b1;
							regWrIdx  <= {1'b0, op_r[11:9]};
							regWrData <= laneLoadVal;
						end
					end
				end
				ST_WRHI: begin
					regWrEn   <= 1'b1;
					regWrIdx  <= {1'b0, ext_r[2:0]};
					regWrData <= hiHold_r;
					done      <= 1'b1;
					busy      <= 1'b0;
					state_r   <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
					busy    <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_quick_sext: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && isQuick |=> regWrEn && regWrData == {{24{$past(op_r[7])}},
		$past(op_r[7:0])})
		else $error("quick move result not the sign-extended byte");

	chk_quick_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && isQuick |=> ccrWrEn && ccrOut[1:0] == 2'b00 &&
		ccrOut[4] == $past(ccrIn[4]) && ccrOut[2] == (regWrData == 32'h0))
		else $error("quick move condition codes wrong");

	chk_priv_trap: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && isSpace && !supervisor |=> trapPrivilege && !busReq ##1 !busy)
		else $error("user-state address-space move not trapped");

	chk_space_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && isSpace && supervisor |=> busReq &&
		busFc == ($past(spToMem) ? $past(destSpaceCode) : $past(sourceSpaceCode)))
		else $error("address-space move drove the wrong function code");

	chk_lane_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_BUS && isLane && busAck && !laneLast |=>
		busReq && busAddr == $past(busAddr) + 32'h2)
		else $error("byte-lane move address did not step by two");

	chk_mul_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && (isMulW || isMulL) |=> ccrWrEn && !ccrOut[0] &&
		ccrOut[4] == $past(ccrIn[4]))
		else $error("multiply carry or extend flag wrong");

	chk_mul_ovf: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && (isMulW || isMulL) |=> ccrOut[1] == ($past(isMulL) &&
		!$past(mul64) && $past(prodL[63:32]) != {32{$past(prodL[31])}}))
		else $error("multiply overflow flag wrong");

	chk_mul_word: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && isMulW |=> regWrEn && regWrData == $past(prodW) && done)
		else $error("word multiply product wrong");

	chk_mul_pair: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && isMulL && mul64 |=> regWrEn && !done ##1
		regWrEn && done && regWrIdx == {1'b0, $past(ext_r[2:0], 2)})
		else $error("64-bit product pair not written");

	chk_illegal_trap: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == ST_EXEC && isIllegal |=> trapIllegal && !regWrEn && !busReq && !ccrWrEn)
		else $error("illegal form executed");

endmodule : move_space_multiply_decode

`default_nettype wire

// [logic/move_space_multiply_pkg.sv]
/*
  Constants shared by the move / address-space / multiply execute block:
  opcode patterns, field positions, size codes, effective-address modes
  and condition-code bit positions.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package move_space_multiply_pkg;

	// ----------------------------------------------------------------
	// operand sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// ----------------------------------------------------------------
	// operation-word patterns
	// ----------------------------------------------------------------
	localparam logic [3:0] QUICK_TOP   = 4'h7;     // bits 15..12
	localparam logic [3:0] LANE_TOP    = 4'h0;     // bits 15..12
	localparam logic [2:0] LANE_EAMODE = 3'h1;     // bits 5..3
	localparam logic [7:0] SPACE_TOP   = 8'h0e;    // bits 15..8
	localparam logic [3:0] MULW_TOP    = 4'hc;     // bits 15..12
	localparam logic [2:0] MULW_OPMODE = 3'h7;     // bits 8..6
	localparam logic [9:0] MULL_TOP    = 10'h130;  // bits 15..6

	// ----------------------------------------------------------------
	// byte-lane move operation modes
	// ----------------------------------------------------------------
	localparam logic [2:0] LANE_LOAD_WORD  = 3'h4;
	localparam logic [2:0] LANE_LOAD_LONG  = 3'h5;
	localparam logic [2:0] LANE_STORE_WORD = 3'h6;
	localparam logic [2:0] LANE_STORE_LONG = 3'h7;
	localparam logic [31:0] LANE_STEP      = 32'h2;
	localparam logic [2:0] LANE_BYTES_WORD = 3'h2;
	localparam logic [2:0] LANE_BYTES_LONG = 3'h4;

	// ----------------------------------------------------------------
	// extension-word fields
	// ----------------------------------------------------------------
	localparam int EXT_AD_BIT     = 15;   // register type, 1 = address
	localparam int EXT_DIR_BIT    = 11;   // address-space move direction_bit
	localparam int EXT_SIGNED_BIT = 11;   // multiply: 1 = signed
	localparam int EXT_SIZE_BIT   = 10;   // multiply: 1 = 64-bit product

	// ----------------------------------------------------------------
	// effective-address modes
	// ----------------------------------------------------------------
	localparam logic [2:0] EA_DREG    = 3'h0;
	localparam logic [2:0] EA_AREG    = 3'h1;
	localparam logic [2:0] EA_POSTINC = 3'h3;
	localparam logic [2:0] EA_PREDEC  = 3'h4;
	localparam logic [2:0] EA_EXT     = 3'h7;
	localparam logic [2:0] EA_ABS_L   = 3'h1;
	localparam logic [2:0] EA_IMM     = 3'h4;

	// ----------------------------------------------------------------
	// condition-code bit positions
	// ----------------------------------------------------------------
	localparam int CC_X = 4;
	localparam int CC_N = 3;
	localparam int CC_Z = 2;
	localparam int CC_V = 1;
	localparam int CC_C = 0;

endpackage : move_space_multiply_pkg

`default_nettype wire

// [tb/far_side.sv]
/* Far-side model: register file and memory bus for the execute block.
   Assumes one bus request at a time, held until after its acknowledge. */
`timescale 1ns/1ps
`default_nettype none
module far_side (
	input  wire logic        clk_sys,    // core clock
	input  wire logic [3:0]  regRdIdxA,  // read index A
	input  wire logic [3:0]  regRdIdxB,  // read index B
	input  wire logic        regWrEn,    // write pulse
	input  wire logic [3:0]  regWrIdx,   // write index
	input  wire logic [31:0] regWrData,  // write data
	input  wire logic        busReq,     // bus request
	input  wire logic [31:0] busAddr,    // bus address
	output logic      [31:0] regRdDataA, // read data A
	output logic      [31:0] regRdDataB, // read data B
	output logic             busAck,     // cycle done
	output logic      [31:0] busRData    // read data
);
	logic [31:0] regs [16];
	logic        ack_r  = 1'b0;
	logic        slow_r = 1'b0;
	logic [31:0] memVal;
	assign regRdDataA = regs[regRdIdxA];
	assign regRdDataB = regs[regRdIdxB];
	assign busAck     = ack_r;
	assign memVal     = 32'h8c3af5e1 ^ busAddr;
	// junk outside the acknowledge, so a late sample cannot pass
	assign busRData   = ack_r ? memVal : ~memVal;
	// one wait cycle on every request: slow_r toggles twice per request
	always @(posedge clk_sys) begin
		if (regWrEn)
			regs[regWrIdx] <= regWrData;
		ack_r <= busReq && !ack_r && slow_r;
		if (busReq && !ack_r)
			slow_r <= !slow_r;
	end
endmodule : far_side
`default_nettype wire

// [tb/move_space_multiply_decode_bench.sv]
/* Bench for the execute block: random and corner words against far_side.
   Assumes one done pulse per accepted word and a 10 ns clock. */
`timescale 1ns/1ps
`default_nettype none
module move_space_multiply_decode_bench;
	logic        clk_sys = 0, reset_n = 0, instrValid = 0, supervisor = 1;
	logic [15:0] opWord = 0, extWord = 0;
	logic [31:0] srcOperand = 0, eaAddr = 0, eaAdjAddr = 0, regRdDataA, regRdDataB, busRData;
	logic [2:0]  sourceSpaceCode = 0, destSpaceCode = 0, busFc, bF[4], bK[4];
	logic [4:0]  ccrIn = 0, ccrOut, cc;
	logic [3:0]  regRdIdxA, regRdIdxB, regWrIdx;
	logic [31:0] regWrData, busAddr, busWData, bA[4], bD[4], a, s, o, e, m;
	logic        busy, regWrEn, ccrWrEn, busReq, busWrite, busAck, trapPrivilege, trapIllegal, done;
	logic [1:0]  busSize, sz;
	logic [63:0] q;
	logic [15:0] bad[5] = '{16'h0e41, 16'h0ed2, 16'h0e3c, 16'hc3c8, 16'h7100};
	int          fails = 0, checks_done = 0, nw, nb, tp, ti, k, n;
	move_space_multiply_decode move_space_multiply_decode_inst (.*);
	far_side far_side_inst (.*);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		nw += int'(regWrEn === 1'b1);
		tp += int'(trapPrivilege === 1'b1);
		ti += int'(trapIllegal === 1'b1);
		if (ccrWrEn === 1'b1) cc = ccrOut;
		if (busAck === 1'b1) begin
			bA[nb[1:0]] = busAddr;
			bD[nb[1:0]] = busWData;
			bF[nb[1:0]] = busFc;
			bK[nb[1:0]] = {busWrite, busSize};
			nb++;
		end
	end
	task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// same pattern as the far-side memory, so expectations stay independent of the design
	function automatic logic [31:0] memAt(logic [31:0] ad);
		return 32'h8c3af5e1 ^ ad;
	endfunction : memAt
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	task automatic run(logic [15:0] op, logic [15:0] ext);
		int t;
		{nw, nb, tp, ti} = '0;
		opWord <= op;
		extWord <= ext;
		srcOperand <= s;
		eaAddr <= a;
		eaAdjAddr <= a + 32'h4;
		{ccrIn, sourceSpaceCode, destSpaceCode} <= 11'($urandom);
		instrValid <= 1'b1;
		@(posedge clk_sys);
		instrValid <= 1'b0;
		for (t = 0; t < 60 && done !== 1'b1; t++) @(posedge clk_sys);
		if (t == 60) fails++;
		if (t == 60) results();
		@(posedge clk_sys);
	endtask : run
	initial begin
		k = $urandom(37);
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		for (k = 0; k < 10; k++) begin
			m = (k == 0) ? 32'h80 : (k == 1) ? 32'h0 : $urandom;
			run({4'h7, k[2:0], 1'b0, m[7:0]}, 16'h0);
			e = {{24{m[7]}}, m[7:0]};
			chk("quick", e, far_side_inst.regs[k[2:0]]);
			chk("quick cc", {ccrIn[4], e[31], e == 0, 2'h0}, cc);
		end
		for (k = 0; k < 12; k++) begin
			s = (k < 3) ? 32'h40008000 : $urandom;
			o = (k < 3) ? 32'h00048000 : $urandom;
			far_side_inst.regs[1] = o;
			sz = 2'(k % 3);
			run(sz == 0 ? 16'hc3c0 : 16'h4c00, {4'h1, 1'b1, sz == 2, 10'h2});
			q = (sz == 0) ? $signed(s[15:0]) * $signed(o[15:0]) : $signed(s) * $signed(o);
			chk("mul low", q[31:0], far_side_inst.regs[1]);
			if (sz == 2) chk("mul high", q[63:32], far_side_inst.regs[2]);
			chk("mul cc", {ccrIn[4], sz == 2 ? q[63] : q[31], sz == 2 ? q == 0 : q[31:0] == 0,
				sz == 1 && q[63:32] != {32{q[31]}}, 1'b0}, cc);
		end
		supervisor <= 1'b0;
		run(16'h0e92, 16'h0);
		chk("priv trap", 1, tp + nb + nw);
		supervisor <= 1'b1;
		foreach (bad[i]) begin
			run(bad[i], 16'h0);
			chk("illegal", 1, ti + nb + nw);
		end
		for (k = 0; k < 12; k++) begin
			sz = 2'(k % 3);
			a = $urandom & ~32'h3 | (sz == 0);
			o = $urandom;
			far_side_inst.regs[{k[0], 3'h5}] = o;
			run({8'h0e, sz, 6'h12}, {k[0], 3'h5, k > 5, 11'h0});
			m = (sz == 0) ? 32'hff : (sz == 1) ? 32'hffff : '1;
			e = memAt(a);
			e = k[0] ? (sz == 0 ? {{24{e[7]}}, e[7:0]} : sz == 1 ? {{16{e[15]}}, e[15:0]} : e)
				: (o & ~m) | (e & m);
			chk("space fc", k > 5 ? destSpaceCode : sourceSpaceCode, bF[0]);
			chk("space addr", a, bA[0]);
			chk("space kind", {k > 5, sz}, bK[0]);
			if (k > 5) chk("space store", o & m, bD[0] & m);
			else chk("space load", e, far_side_inst.regs[{k[0], 3'h5}]);
		end
		a = $urandom & ~32'h3;
		run(16'h0e9d, 16'hd800);
		chk("self store", 32'(a + 4), bD[0]);
		for (k = 4; k < 8; k++) begin
			a = $urandom | 32'h1;
			o = $urandom;
			far_side_inst.regs[11] = a;
			far_side_inst.regs[2] = o;
			run({7'h02, k[2:0], 6'h0b}, 16'hfffe);
			n = k[0] ? 4 : 2;
			e = o;
			for (int j = 0; j < n; j++) begin
				chk("lane addr", 32'(a - 2 + 2 * j), bA[j]);
				chk("lane kind", {k > 5, 2'h0}, bK[j]);
				if (k > 5) chk("lane byte", (o >> (8 * (n - 1 - j))) & 32'hff, bD[j] & 32'hff);
				e = (e << 8) | (memAt(a - 2 + 2 * j) & 32'hff);
			end
			if (k < 6) chk("lane load", n == 2 ? {o[31:16], e[15:0]} : e, far_side_inst.regs[2]);
		end
		results();
	end
endmodule : move_space_multiply_decode_bench
`default_nettype wire
